// ### rtl/prmt_pkg.sv
// Purpose: shared constants and types for the resolved-mode status and test register bank
// Assumes: one management clock, synchronous active-high reset
// Notes:   register offsets are byte offsets; the management frame carries the word index
package prmt_pkg;

  // register byte offsets and their word indices on the management frame
  localparam logic [7:0] STATUS_OFS = 8'h3a;
  localparam logic [7:0] TEST_OFS   = 8'h3c;
  localparam logic [4:0] STATUS_IDX = STATUS_OFS[5:1];
  localparam logic [4:0] TEST_IDX   = TEST_OFS[5:1];

  // status view field positions
  localparam int SHADOW_SEL_BIT = 15;
  localparam int NO_GIG_BIT     = 14;
  localparam int NO_100_BIT     = 13;
  localparam int EVT_W          = 13;   // latched bits [12:0]

  // test register field positions
  localparam int CRC_SEL_BIT    = 15;
  localparam int TXERR_VIS_BIT  = 14;
  localparam int FORCE_LINK_BIT = 12;
  localparam int MDI_SWAP_BIT   = 7;

  // values after reset
  localparam logic [15:0] TEST_RESET   = 16'h0000;
  localparam logic [10:0] SEED_RESET   = 11'h000;
  localparam logic        SHADOW_RESET = 1'b0;

  // management frame counts
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;  // 32 ones before the first frame
  localparam logic [4:0] HDR_LAST      = 5'h0b;  // op, phy address, register address
  localparam logic [4:0] DATA_LAST     = 5'h0f;  // sixteen data bits
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;

  // frame receiver states
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_START = 6'b000010,
    S_HDR   = 6'b000100,
    S_TA    = 6'b001000,
    S_DATA  = 6'b010000,
    S_SPARE = 6'b100000
  } prmt_state_t;

  // event pulses from the negotiation and link logic, packed as bits [12:0]
  typedef struct packed {
    logic       downgrade;  // speed downgrade happened
    logic [5:0] mode;       // gig fd, gig hd, 100 fd, 100 hd, 10 fd, 10 hd resolved
    logic [5:0] nolink;     // same order, resolved but link never came up
  } prmt_event_t;

  // test controls driven to the data path
  typedef struct packed {
    logic crc_count_sel;    // receive fault counter counts crc errors
    logic txerr_visible;    // false carrier counter counts tx error codes
    logic force_link_pass;  // link state machine held in link pass
    logic mdi_swap;         // manual mdi pair swap
  } prmt_test_t;

endpackage

// ### rtl/prmt_sticky.sv
// Purpose: bank of latch-high event bits with a common clear
// Assumes: set and clear are pulses on clk_sys
// Notes:   a set in the clear cycle wins, so no event is lost
`timescale 1ns/1ps
`default_nettype none
module prmt_sticky #(
  parameter int W = 13
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] set_vec,  // one pulse per event
  input  wire logic         clr,      // clears all bits
  output logic      [W-1:0] q         // latched bits
);

  logic [W-1:0] next_q;  // next latched value

  // set wins over clear
  always_comb begin
    next_q = (q & ~{W{clr}}) | set_vec;
  end

  // register the latched bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule // prmt_sticky
`default_nettype wire

// ### rtl/prmt_regs.sv
// Purpose: resolved-mode status view and test register behind the serial management pins
// Assumes: mdc and mdio come from pins and are synchronised here; events are on clk_sys
// Notes:   the shadow bit selects between seed view and resolved-mode status view
`timescale 1ns/1ps
`default_nettype none
module prmt_regs (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 mdc,            // management clock pin
  input  wire logic                 mdio_i,         // management data pin in
  output logic                      mdio_o,         // management data out
  output logic                      mdio_oe,        // high while driving
  input  wire logic [4:0]           phy_addr,       // port address on the frame
  input  wire prmt_pkg::prmt_event_t ev,            // event pulses
  input  wire logic                 adv_no_gig,     // gigabit advertising suppressed
  input  wire logic                 adv_no_100,     // 100TX advertising suppressed
  input  wire logic                 an_disable_set, // pulse: negotiation disabled
  input  wire logic                 an_restart_set, // pulse: negotiation restarted
  input  wire logic [3:0]           seed_status,    // seed view bits 14..11
  output prmt_pkg::prmt_test_t      test_ctrl       // test controls
);

  // pin synchronisers
  logic mdc_s1, mdc_s2, mdc_s3;   // mdc stages, s3 for edge
  logic mdio_s1, mdio_s2;         // mdio stages
  logic mdc_rise;                 // rising edge of mdc

  // frame receiver state
  prmt_pkg::prmt_state_t state, next_state;  // receiver state
  logic [4:0]  bit_cnt, next_bit_cnt;        // bit within field
  logic [5:0]  ones_cnt, next_ones_cnt;      // preamble ones seen
  logic        pre_seen, next_pre_seen;      // first preamble done
  logic [11:0] hdr, next_hdr;                // op, phy, register
  logic [15:0] shift, next_shift;            // data shifter
  logic        is_read, next_is_read;        // read frame
  logic        hit, next_hit;                // frame for this port
  logic        next_mdio_o, next_mdio_oe;    // pin drive

  // register storage
  logic        shadow_sel, next_shadow_sel;  // status view selected
  logic [10:0] seed_val, next_seed_val;      // seed bits
  logic [15:0] test_reg, next_test_reg;      // test register

  // helpers
  logic [11:0] hdr_full;     // header including current bit
  logic [15:0] wr_word;      // write data including current bit
  logic        wr_commit;    // write completes this cycle
  logic        rd_clear;     // status read clears latched bits
  logic        evt_clr;      // any clear source
  logic [prmt_pkg::EVT_W-1:0] evt;  // latched bits [12:0]
  logic [15:0] rd_data;      // read mux

  // synchroniser stages only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mdc_s1  <= 1'b0;
      mdc_s2  <= 1'b0;
      mdc_s3  <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
    end else begin
      mdc_s1  <= mdc;
      mdc_s2  <= mdc_s1;
      mdc_s3  <= mdc_s2;
      mdio_s1 <= mdio_i;
      mdio_s2 <= mdio_s1;
    end
  end

  assign mdc_rise = mdc_s2 & ~mdc_s3;
  assign hdr_full = {hdr[10:0], mdio_s2};
  assign wr_word  = {shift[14:0], mdio_s2};
  assign evt_clr  = rd_clear | an_disable_set | an_restart_set;

  // read mux: status view, seed view, test register
  always_comb begin
    rd_data = 16'h0000;
    if (hdr_full[4:0] == prmt_pkg::STATUS_IDX) begin
      if (shadow_sel) begin
        rd_data = {1'b1, adv_no_gig, adv_no_100, evt};
      end else begin
        rd_data = {1'b0, seed_status, seed_val};
      end
    end else if (hdr_full[4:0] == prmt_pkg::TEST_IDX) begin
      rd_data = test_reg;
    end
  end

  // latched event bits, set wins over clear
  prmt_sticky #(
    .W (prmt_pkg::EVT_W)
  ) prmt_sticky_inst (
    .clk_sys (clk_sys),
    .rst     (rst),
    .set_vec (ev),
    .clr     (evt_clr),
    .q       (evt)
  );

  // frame receiver and register writes
  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_ones_cnt   = ones_cnt;
    next_pre_seen   = pre_seen;
    next_hdr        = hdr;
    next_shift      = shift;
    next_is_read    = is_read;
    next_hit        = hit;
    next_mdio_o     = mdio_o;
    next_mdio_oe    = mdio_oe;
    next_shadow_sel = shadow_sel;
    next_seed_val   = seed_val;
    next_test_reg   = test_reg;
    rd_clear        = 1'b0;
    wr_commit       = 1'b0;
    if (mdc_rise) begin
      case (state)
        prmt_pkg::S_IDLE: begin
          if (mdio_s2) begin
            // count preamble ones, saturating
            if (ones_cnt != prmt_pkg::PREAMBLE_ONES) begin
              next_ones_cnt = ones_cnt + 6'h01;
            end
          end else begin
            // start bit: preamble needed only before first frame
            if (pre_seen || ones_cnt == prmt_pkg::PREAMBLE_ONES) begin
              next_state = prmt_pkg::S_START;
            end
            next_ones_cnt = 6'h00;
          end
        end
        prmt_pkg::S_START: begin
          // second start bit must be one
          next_bit_cnt = 5'h00;
          next_state   = mdio_s2 ? prmt_pkg::S_HDR : prmt_pkg::S_IDLE;
        end
        prmt_pkg::S_HDR: begin
          next_hdr     = hdr_full;
          next_bit_cnt = bit_cnt + 5'h01;
          if (bit_cnt == prmt_pkg::HDR_LAST) begin
            next_bit_cnt  = 5'h00;
            next_pre_seen = 1'b1;
            next_is_read  = (hdr_full[11:10] == prmt_pkg::OP_READ);
            next_hit      = (hdr_full[9:5] == phy_addr) &&
                            (hdr_full[11:10] == prmt_pkg::OP_READ || hdr_full[11:10] == prmt_pkg::OP_WRITE);
            next_state    = prmt_pkg::S_TA;
            if (hdr_full[11:10] == prmt_pkg::OP_READ && hdr_full[9:5] == phy_addr) begin
              next_shift = rd_data;
              // status view read clears latched bits
              rd_clear   = shadow_sel && hdr_full[4:0] == prmt_pkg::STATUS_IDX;
            end
          end
        end
        prmt_pkg::S_TA: begin
          if (bit_cnt == 5'h00) begin
            // second turnaround bit: drive zero on a read
            next_bit_cnt = 5'h01;
            if (is_read && hit) begin
              next_mdio_oe = 1'b1;
              next_mdio_o  = 1'b0;
            end
          end else begin
            next_bit_cnt = 5'h00;
            next_state   = prmt_pkg::S_DATA;
            if (is_read && hit) begin
              next_mdio_o = shift[15];
              next_shift  = {shift[14:0], 1'b0};
            end
          end
        end
        prmt_pkg::S_DATA: begin
          next_bit_cnt = bit_cnt + 5'h01;
          if (is_read) begin
            if (bit_cnt == prmt_pkg::DATA_LAST) begin
              // last bit sent, release the pin
              next_mdio_oe = 1'b0;
              next_mdio_o  = 1'b0;
              next_state   = prmt_pkg::S_IDLE;
            end else if (hit) begin
              next_mdio_o = shift[15];
              next_shift  = {shift[14:0], 1'b0};
            end
          end else begin
            next_shift = wr_word;
            if (bit_cnt == prmt_pkg::DATA_LAST) begin
              next_state = prmt_pkg::S_IDLE;
              wr_commit  = hit;
              if (hit && hdr[4:0] == prmt_pkg::STATUS_IDX) begin
                // one access selects the view, seed bits only in seed view
                next_shadow_sel = wr_word[prmt_pkg::SHADOW_SEL_BIT];
                if (!wr_word[prmt_pkg::SHADOW_SEL_BIT]) begin
                  next_seed_val = wr_word[10:0];
                end
              end else if (hit && hdr[4:0] == prmt_pkg::TEST_IDX) begin
                next_test_reg = wr_word;
              end
            end
          end
        end
        default: begin
          next_state   = prmt_pkg::S_IDLE;
          next_mdio_oe = 1'b0;
        end
      endcase
    end
  end

  // register receiver and storage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state      <= prmt_pkg::S_IDLE;
      bit_cnt    <= 5'h00;
      ones_cnt   <= 6'h00;
      pre_seen   <= 1'b0;
      hdr        <= 12'h000;
      shift      <= 16'h0000;
      is_read    <= 1'b0;
      hit        <= 1'b0;
      mdio_o     <= 1'b0;
      mdio_oe    <= 1'b0;
      shadow_sel <= prmt_pkg::SHADOW_RESET;
      seed_val   <= prmt_pkg::SEED_RESET;
      test_reg   <= prmt_pkg::TEST_RESET;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      ones_cnt   <= next_ones_cnt;
      pre_seen   <= next_pre_seen;
      hdr        <= next_hdr;
      shift      <= next_shift;
      is_read    <= next_is_read;
      hit        <= next_hit;
      mdio_o     <= next_mdio_o;
      mdio_oe    <= next_mdio_oe;
      shadow_sel <= next_shadow_sel;
      seed_val   <= next_seed_val;
      test_reg   <= next_test_reg;
    end
  end

  // test controls straight from register bits
  assign test_ctrl.crc_count_sel   = test_reg[prmt_pkg::CRC_SEL_BIT];
  assign test_ctrl.txerr_visible   = test_reg[prmt_pkg::TXERR_VIS_BIT];
  assign test_ctrl.force_link_pass = test_reg[prmt_pkg::FORCE_LINK_BIT];
  assign test_ctrl.mdi_swap        = test_reg[prmt_pkg::MDI_SWAP_BIT];

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  downgrade_latch_a: assert property (ev.downgrade |=> evt[12] [*1] ##1 (evt[12] || $past(evt_clr))) else $error("downgrade not latched");
  event_kept_a: assert property (ev.downgrade && rd_clear |=> evt[12]) else $error("event lost on read clear");
  read_clear_a: assert property (rd_clear && ev == '0 |=> evt == '0) else $error("read did not clear");
  an_clear_a: assert property ((an_disable_set || an_restart_set) && ev == '0 |=> evt == '0) else $error("negotiation clear missed");
  mode_latch_a: assert property (ev.mode[5] && !evt[11] |=> evt[11]) else $error("gig full not latched");
  nolink_latch_a: assert property (ev.nolink[0] |=> evt[0]) else $error("10 half nolink not latched");
  status_view_a: assert property (rd_clear |=> shift[15:13] == {1'b1, $past(adv_no_gig), $past(adv_no_100)}) else $error("status view wrong");
  preamble_a: assert property (state == prmt_pkg::S_IDLE && next_state == prmt_pkg::S_START && !pre_seen |-> ones_cnt == prmt_pkg::PREAMBLE_ONES) else $error("frame without preamble");
  shadow_write_a: assert property (wr_commit && hdr[4:0] == prmt_pkg::STATUS_IDX |=> shadow_sel == $past(wr_word[15])) else $error("shadow select not written");
  crc_sel_a: assert property (wr_commit && hdr[4:0] == prmt_pkg::TEST_IDX |=> test_ctrl.crc_count_sel == $past(wr_word[15])) else $error("crc select wrong");
  txerr_a: assert property (wr_commit && hdr[4:0] == prmt_pkg::TEST_IDX |=> test_ctrl.txerr_visible == $past(wr_word[14])) else $error("txerr select wrong");
  force_link_a: assert property (wr_commit && hdr[4:0] == prmt_pkg::TEST_IDX |=> test_ctrl.force_link_pass == $past(wr_word[12])) else $error("force link wrong");
  mdi_swap_a: assert property (wr_commit && hdr[4:0] == prmt_pkg::TEST_IDX |=> test_ctrl.mdi_swap == $past(wr_word[7])) else $error("mdi swap wrong");

  status_read_c: cover property (rd_clear && evt != '0);
  test_write_c: cover property (wr_commit && hdr[4:0] == prmt_pkg::TEST_IDX);
  no_preamble_c: cover property (state == prmt_pkg::S_IDLE && next_state == prmt_pkg::S_START && ones_cnt != prmt_pkg::PREAMBLE_ONES);
  set_clear_c: cover property (rd_clear && ev != '0);

endmodule // prmt_regs
`default_nettype wire

// ### verification/prmt_mgmt_master.sv
// Purpose: management station model that clocks frames into the register bank
// Assumes: mdc phases of 5 clk_sys each, pins change at the falling clk_sys edge
// Notes:   mdc stands low between frames; a released line reads the pull-up
`timescale 1ns/1ps
`default_nettype none
module prmt_mgmt_master (
  input  wire logic clk_sys,   // system clock
  output logic      mdc,       // management clock
  output logic      mdio_m,    // station data out
  output logic      mdio_m_oe, // station drives mdio
  input  wire logic mdio       // resolved wire
);
  // idle: clock still, line released
  initial begin
    mdc       = 1'b0;
    mdio_m    = 1'b1;
    mdio_m_oe = 1'b0;
  end

  // one bit: set while low, sample just before the rise
  task automatic bit_io(input logic b, input logic drv, output logic s);
    mdio_m    = b;
    mdio_m_oe = drv;
    repeat (5) @(negedge clk_sys);
    s   = mdio;
    mdc = 1'b1;
    repeat (5) @(negedge clk_sys);
    mdc = 1'b0;
  endtask

  // whole frame, msb first; read data taken from bits 16..31
  task automatic xfer(input logic pre, input logic [4:0] pa, input logic [1:0] op,
                      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] q);
    logic [31:0] f;
    logic        s;
    logic        rd;
    int          i;
    rd = (op == prmt_pkg::OP_READ);  // only a read hands the line over
    f = {2'b01, op, pa, ra, 2'b10, wd};
    q = 16'h0000;
    if (pre) begin
      for (i = 0; i < 32; i++) bit_io(1'b1, 1'b1, s);
    end
    for (i = 0; i < 32; i++) begin
      bit_io(f[31-i], !(rd && i >= 14), s);
      if (i >= 16) q[31-i] = s;
    end
    mdio_m_oe = 1'b0;
    mdio_m    = 1'b1;
    // one edge released, so a following frame never re-drives in this step
    @(negedge clk_sys);
  endtask
endmodule // prmt_mgmt_master
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: self-checking bench for the status view and test register
// Assumes: inputs change at the falling clk_sys edge
// Notes:   random values from a 16-bit lfsr seeded with 60
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [4:0] PA = 5'h05;     // port address under test
  logic                  clk_sys;        // 200 MHz
  logic                  rst;            // sync reset
  logic                  mdc;            // management clock
  logic                  mdio_m;         // station data
  logic                  mdio_m_oe;      // station enable
  logic                  mdio_o;         // device data
  logic                  mdio_oe;        // device enable
  wire logic             mdio;           // resolved wire
  logic                  adv_no_gig;     // gig suppressed level
  logic                  adv_no_100;     // 100 suppressed level
  logic                  an_disable_set; // clear pulse
  logic                  an_restart_set; // clear pulse
  logic [3:0]            seed_status;    // seed view bits
  prmt_pkg::prmt_event_t ev;             // event pulses
  prmt_pkg::prmt_test_t  test_ctrl;      // test controls
  int                    n_mismatch;     // mismatches
  int                    num_checks;     // comparisons
  int                    i;              // loop index
  logic [15:0]           lfsr;           // random state
  logic [15:0]           q;              // read data
  logic [15:0]           w;              // written word
  logic [12:0]           e;              // expected latched bits

  // pull-up when nobody drives
  assign mdio = mdio_oe ? mdio_o : (mdio_m_oe ? mdio_m : 1'b1);

  prmt_regs prmt_regs_inst (
    .clk_sys(clk_sys), .rst(rst), .mdc(mdc), .mdio_i(mdio), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .phy_addr(PA), .ev(ev), .adv_no_gig(adv_no_gig),
    .adv_no_100(adv_no_100), .an_disable_set(an_disable_set),
    .an_restart_set(an_restart_set), .seed_status(seed_status), .test_ctrl(test_ctrl)
  );

  prmt_mgmt_master prmt_mgmt_master_inst (
    .clk_sys(clk_sys), .mdc(mdc), .mdio_m(mdio_m), .mdio_m_oe(mdio_m_oe), .mdio(mdio)
  );

  // clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // lfsr step
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // expected status view word
  function automatic logic [15:0] exp_stat(input logic [12:0] lat);
    return {1'b1, adv_no_gig, adv_no_100, lat};
  endfunction

  // expected test controls from a test word
  function automatic logic [15:0] exp_ctrl(input logic [15:0] d);
    return {12'h000, d[15], d[14], d[12], d[7]};
  endfunction

  // compare and count
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // frames without preamble after the first
  task automatic rd_reg(input logic [4:0] ra, output logic [15:0] d);
    prmt_mgmt_master_inst.xfer(1'b0, PA, prmt_pkg::OP_READ, ra, 16'h0000, d);
  endtask

  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    prmt_mgmt_master_inst.xfer(1'b0, PA, prmt_pkg::OP_WRITE, ra, d, x);
  endtask

  // one-cycle pulses on events and clears
  task automatic pulse(input logic [12:0] p, input logic dis, input logic rs);
    ev             = prmt_pkg::prmt_event_t'(p);
    an_disable_set = dis;
    an_restart_set = rs;
    @(negedge clk_sys);
    ev             = '0;
    an_disable_set = 1'b0;
    an_restart_set = 1'b0;
    @(negedge clk_sys);
  endtask

  // verdict
  task automatic end_sim();
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end

  // main sequence
  initial begin
    rst = 1'b1; ev = '0; adv_no_gig = 1'b0; adv_no_100 = 1'b0;
    an_disable_set = 1'b0; an_restart_set = 1'b0; seed_status = 4'h0;
    lfsr = 16'h003c; n_mismatch = 0; num_checks = 0;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    // no preamble yet: refused
    prmt_mgmt_master_inst.xfer(1'b0, PA, prmt_pkg::OP_WRITE, prmt_pkg::TEST_IDX, 16'h8080, q);
    check("ctrl no preamble", {12'h000, test_ctrl}, 16'h0000);
    prmt_mgmt_master_inst.xfer(1'b1, PA, prmt_pkg::OP_READ, prmt_pkg::TEST_IDX, 16'h0000, q);
    check("test reset", q, prmt_pkg::TEST_RESET);
    // test register controls, reserved bits kept zero
    for (i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      w = (i == 0) ? 16'hd080 : (lfsr & 16'hd080);
      wr_reg(prmt_pkg::TEST_IDX, w);
      check("test_ctrl", {12'h000, test_ctrl}, exp_ctrl(w));
      rd_reg(prmt_pkg::TEST_IDX, q);
      check("test readback", q, w);
    end
    // other port address: ignored and silent
    prmt_mgmt_master_inst.xfer(1'b0, PA ^ 5'h01, prmt_pkg::OP_WRITE, prmt_pkg::TEST_IDX, w ^ 16'hd080, q);
    check("ctrl other port", {12'h000, test_ctrl}, exp_ctrl(w));
    prmt_mgmt_master_inst.xfer(1'b0, PA ^ 5'h01, prmt_pkg::OP_READ, prmt_pkg::TEST_IDX, 16'h0000, q);
    check("other port read", q, 16'hffff);
    // reserved op code: clocked through, nothing written
    prmt_mgmt_master_inst.xfer(1'b0, PA, 2'h3, prmt_pkg::TEST_IDX, w ^ 16'hd080, q);
    check("ctrl bad op", {12'h000, test_ctrl}, exp_ctrl(w));
    // swap change: leave link pass first, then set the swap bit
    wr_reg(prmt_pkg::TEST_IDX, 16'h0000);
    wr_reg(prmt_pkg::TEST_IDX, 16'h0080);
    check("mdi swap order", {12'h000, test_ctrl}, exp_ctrl(16'h0080));
    // seed view and unmapped word
    lfsr = lfsr_next(lfsr);
    seed_status = lfsr[15:12];
    pulse(13'h1fff, 1'b0, 1'b0);
    wr_reg(prmt_pkg::STATUS_IDX, {5'h00, lfsr[10:0]});
    rd_reg(prmt_pkg::STATUS_IDX, q);
    check("seed view", q, {1'b0, seed_status, lfsr[10:0]});
    rd_reg(5'h00, q);
    check("unmapped", q, 16'h0000);
    // select status view in one write; seed-view read kept the events
    wr_reg(prmt_pkg::STATUS_IDX, 16'h8000);
    rd_reg(prmt_pkg::STATUS_IDX, q);
    check("status first", q, exp_stat(13'h1fff));
    // walking ones then random pairs of events
    for (i = 0; i < 18; i++) begin
      lfsr = lfsr_next(lfsr);
      adv_no_gig = lfsr[14];
      adv_no_100 = lfsr[15];
      e = (i < 13) ? (13'h0001 << i) : lfsr[12:0];
      pulse(e, 1'b0, 1'b0);
      lfsr = lfsr_next(lfsr);
      if (i >= 13) e = e | lfsr[12:0];
      if (i >= 13) pulse(lfsr[12:0], 1'b0, 1'b0);
      rd_reg(prmt_pkg::STATUS_IDX, q);
      check("status latched", q, exp_stat(e));
      rd_reg(prmt_pkg::STATUS_IDX, q);
      check("status cleared", q, exp_stat(13'h0000));
    end
    // clears by disable and restart; set in the clear cycle survives
    for (i = 0; i < 2; i++) begin
      lfsr = lfsr_next(lfsr);
      pulse(lfsr[12:0] | 13'h0001, 1'b0, 1'b0);
      pulse(13'h0000, i == 0, i == 1);
      rd_reg(prmt_pkg::STATUS_IDX, q);
      check("status an clear", q, exp_stat(13'h0000));
      pulse(13'h1ff0, 1'b0, 1'b0);
      pulse(13'h000a, i == 1, i == 0);
      rd_reg(prmt_pkg::STATUS_IDX, q);
      check("status set wins", q, exp_stat(13'h000a));
    end
    // mid-run reset: preamble needed again, seed view and latches cleared
    pulse(13'h1fff, 1'b0, 1'b0);
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    prmt_mgmt_master_inst.xfer(1'b0, PA, prmt_pkg::OP_WRITE, prmt_pkg::TEST_IDX, 16'hd080, q);
    check("ctrl reset no preamble", {12'h000, test_ctrl}, 16'h0000);
    prmt_mgmt_master_inst.xfer(1'b1, PA, prmt_pkg::OP_READ, prmt_pkg::STATUS_IDX, 16'h0000, q);
    check("seed after reset", q, {1'b0, seed_status, prmt_pkg::SEED_RESET});
    wr_reg(prmt_pkg::STATUS_IDX, 16'h8000);
    rd_reg(prmt_pkg::STATUS_IDX, q);
    check("status after reset", q, exp_stat(13'h0000));
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
